// >>> inc/epfm_pkg.sv
package epfm_pkg;
  // role selection for each multiplexed pin
  typedef enum logic [1:0] {
    EPFM_ROLE_EEPROM  = 2'b00,
    EPFM_ROLE_GENERAL = 2'b01,
    EPFM_ROLE_MON_A   = 2'b10,
    EPFM_ROLE_MON_B   = 2'b11
  } epfm_role_e;

  localparam int unsigned EPFM_ROLE_W  = 2;
  localparam logic        EPFM_SEL_OFF = 1'b0;
  localparam logic        EPFM_STRAP_RST = 1'b0;
  localparam int unsigned EPFM_BUS_WIDE   = 32;
  localparam int unsigned EPFM_BUS_NARROW = 16;
  localparam logic [5:0]  EPFM_WIDTH_WIDE   = 6'h20;
  localparam logic [5:0]  EPFM_WIDTH_NARROW = 6'h10;
endpackage : epfm_pkg

// >>> logic/epfm_sync.sv
module epfm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : epfm_sync

// >>> logic/epfm_strap.sv
module epfm_strap (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic level_i,
  output logic      strap_o
);
  logic [2:0] rst_dly_q;
  wire logic  capture;

  // the synchroniser is cleared in reset too, so the pin level seen at
  // release reaches level_i two edges later; take it exactly there
  assign capture = rst_dly_q[2] & ~rst_dly_q[1];

  always_ff @(posedge clk_i) begin
    rst_dly_q <= {rst_dly_q[1:0], sys_rst_i};
    if (sys_rst_i) begin
      strap_o <= epfm_pkg::EPFM_STRAP_RST;
    end else if (capture) begin
      strap_o <= level_i;
    end
  end

  a_strap_hold: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !capture |=> $stable(strap_o))
    else $error("strap changed after capture");

  a_strap_capture: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    capture |=> strap_o == $past(level_i))
    else $error("strap not taken from release level");
endmodule : epfm_strap

// >>> logic/epfm_mux.sv
// Notes on behaviour
// - eeprom role: data pin bidirectional
// - data pin: general output or tx monitor
// - data pin alternate role forces select off
// - clock pin: general output or rx monitor
// - clock pin alternate role forces select off
// - general outputs are output only
// - dedicated select output from access logic
// - data pin strap latched at reset release
// - strap high 32 bit, low 16 bit
// - reversal swaps transmit and receive pairs
// - auto crossover enabled only when input high; manual reversal swaps regardless
module epfm_mux (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [1:0] data_role_i,
  input  wire logic [1:0] clk_role_i,
  input  wire logic       general_output_3_i,
  input  wire logic       general_output_4_i,
  input  wire logic       mii_tx_en_i,
  input  wire logic       mii_tx_clk_i,
  input  wire logic       mii_rx_dv_i,
  input  wire logic       mii_rx_clk_i,
  input  wire logic       ee_data_out_i,
  input  wire logic       ee_data_oe_i,
  input  wire logic       ee_clock_i,
  input  wire logic       ee_select_i,
  output logic            ee_data_in_o,
  input  wire logic       eeprom_data_io_i,
  output logic            eeprom_data_io_o,
  output logic            eeprom_data_io_oe_o,
  output logic            eeprom_serial_clock_o,
  output logic            eeprom_select_o,
  input  wire logic       crossover_auto_enable_i,
  input  wire logic       reverse_detected_i,
  input  wire logic       reverse_manual_i,
  output logic            pairs_swapped_o,
  output logic            pair_a_transmit_o,
  output logic            pair_b_transmit_o,
  output logic            bus_width_strap_o,
  output logic [5:0]      bus_width_o
);
  logic [1:0] data_role_q;
  logic [1:0] clk_role_q;
  logic       data_out_q;
  logic       data_oe_q;
  logic       clk_out_q;
  logic       select_q;
  logic       swap_q;

  wire logic [4:0] pin_sync;
  wire logic       data_pin_s;
  wire logic       auto_s;
  wire logic       det_s;
  wire logic       txclk_s;
  wire logic       rxclk_s;

  epfm_sync #(.WIDTH(5)) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({eeprom_data_io_i, crossover_auto_enable_i,
                 reverse_detected_i, mii_tx_clk_i, mii_rx_clk_i}),
    .sync_o    (pin_sync)
  );
  assign data_pin_s = pin_sync[4];
  assign auto_s     = pin_sync[3];
  assign det_s      = pin_sync[2];
  assign txclk_s    = pin_sync[1];
  assign rxclk_s    = pin_sync[0];

  epfm_strap u_strap (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .level_i   (data_pin_s),
    .strap_o   (bus_width_strap_o)
  );

  function automatic logic pick(input logic [1:0] role, input logic ee,
                                input logic gp, input logic ma,
                                input logic mb);
    case (role)
      epfm_pkg::EPFM_ROLE_EEPROM:  pick = ee;
      epfm_pkg::EPFM_ROLE_GENERAL: pick = gp;
      epfm_pkg::EPFM_ROLE_MON_A:   pick = ma;
      epfm_pkg::EPFM_ROLE_MON_B:   pick = mb;
      default:                     pick = ee;
    endcase
  endfunction : pick

  wire logic data_ee  = (data_role_q == epfm_pkg::EPFM_ROLE_EEPROM);
  wire logic clk_ee   = (clk_role_q == epfm_pkg::EPFM_ROLE_EEPROM);
  // either pin in an alternate role blocks any stray access
  wire logic sel_d    = (data_ee && clk_ee) ? ee_select_i
                        : epfm_pkg::EPFM_SEL_OFF;
  wire logic dout_d   = pick(data_role_q, ee_data_out_i, general_output_3_i,
                             mii_tx_en_i, txclk_s);
  wire logic doe_d    = data_ee ? ee_data_oe_i : 1'b1;
  wire logic cout_d   = pick(clk_role_q, ee_clock_i, general_output_4_i,
                             mii_rx_dv_i, rxclk_s);
  wire logic swap_d   = reverse_manual_i | (auto_s & det_s);

  // role registers give a clean switch point; monitored clocks are
  // resampled, so a monitor clock reads at most half the system rate
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      data_role_q <= epfm_pkg::EPFM_ROLE_EEPROM;
      clk_role_q  <= epfm_pkg::EPFM_ROLE_EEPROM;
      data_out_q  <= 1'b0;
      data_oe_q   <= 1'b0;
      clk_out_q   <= 1'b0;
      select_q    <= epfm_pkg::EPFM_SEL_OFF;
      swap_q      <= 1'b0;
    end else begin
      data_role_q <= data_role_i;
      clk_role_q  <= clk_role_i;
      data_out_q  <= dout_d;
      data_oe_q   <= doe_d;
      clk_out_q   <= cout_d;
      select_q    <= sel_d;
      swap_q      <= swap_d;
    end
  end

  assign eeprom_data_io_o      = data_out_q;
  assign eeprom_data_io_oe_o   = data_oe_q;
  assign eeprom_serial_clock_o = clk_out_q;
  assign eeprom_select_o       = select_q;
  assign ee_data_in_o          = data_pin_s;
  assign pairs_swapped_o       = swap_q;
  assign pair_a_transmit_o     = ~swap_q;
  assign pair_b_transmit_o     = swap_q;
  assign bus_width_o = bus_width_strap_o ? epfm_pkg::EPFM_WIDTH_WIDE
                       : epfm_pkg::EPFM_WIDTH_NARROW;

  // checks share the registered role views
  wire logic data_alt = !data_ee;
  wire logic clk_alt  = !clk_ee;

  // a role change is taken first, then applied from the role register
  sequence s_data_general;
    (data_role_i == epfm_pkg::EPFM_ROLE_GENERAL)
    ##1 (data_role_q == epfm_pkg::EPFM_ROLE_GENERAL);
  endsequence : s_data_general

  sequence s_data_leaves;
    (data_role_i != epfm_pkg::EPFM_ROLE_EEPROM)
    ##1 data_alt;
  endsequence : s_data_leaves

  sequence s_clk_leaves;
    (clk_role_i != epfm_pkg::EPFM_ROLE_EEPROM)
    ##1 clk_alt;
  endsequence : s_clk_leaves

  // select may only come back once both pins are home again
  sequence s_back_home;
    (data_alt || clk_alt) ##1 (data_ee && clk_ee);
  endsequence : s_back_home

  // select gating
  a_select_blocked: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    data_alt |=> !eeprom_select_o)
    else $error("select active in data alternate role");

  a_select_clkpin: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    clk_alt |=> !eeprom_select_o)
    else $error("select active in clock alternate role");

  a_select_follow: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (data_ee && clk_ee) |=> eeprom_select_o == $past(ee_select_i))
    else $error("select not following access logic");

  a_select_source: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    eeprom_select_o |-> $past(ee_select_i))
    else $error("select raised without access logic");

  a_data_leaves: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    s_data_leaves |=> !eeprom_select_o)
    else $error("select kept after data pin left");

  a_clk_switch: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    s_clk_leaves |=> !eeprom_select_o)
    else $error("select kept after clock pin left");

  a_back_home: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    s_back_home |=> eeprom_select_o == $past(ee_select_i))
    else $error("select not restored after return");

  // data pin roles
  a_ee_data_pass: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    data_ee |=> eeprom_data_io_o == $past(ee_data_out_i))
    else $error("eeprom data out wrong");

  a_ee_oe_pass: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    data_ee |=> eeprom_data_io_oe_o == $past(ee_data_oe_i))
    else $error("eeprom data enable wrong");

  a_general_drive: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (data_role_q == epfm_pkg::EPFM_ROLE_GENERAL) |=>
      eeprom_data_io_oe_o && eeprom_data_io_o == $past(general_output_3_i))
    else $error("general output 3 not driven");

  a_tx_en_monitor: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (data_role_q == epfm_pkg::EPFM_ROLE_MON_A) |=>
      eeprom_data_io_o == $past(mii_tx_en_i))
    else $error("tx enable monitor wrong");

  a_tx_clk_monitor: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (data_role_q == epfm_pkg::EPFM_ROLE_MON_B) |=>
      eeprom_data_io_o == $past(txclk_s))
    else $error("tx clock monitor wrong");

  a_data_switch: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    s_data_general |=> eeprom_data_io_oe_o && !eeprom_select_o)
    else $error("general role not applied");

  // no input path: an alternate role always drives the pin
  a_no_input: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    data_alt |=> eeprom_data_io_oe_o)
    else $error("data pin released in output role");

  // clock pin roles
  a_general_clk: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (clk_role_q == epfm_pkg::EPFM_ROLE_GENERAL) |=>
      eeprom_serial_clock_o == $past(general_output_4_i))
    else $error("general output 4 not driven");

  a_rx_monitor: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (clk_role_q == epfm_pkg::EPFM_ROLE_MON_A) |=>
      eeprom_serial_clock_o == $past(mii_rx_dv_i))
    else $error("rx valid monitor wrong");

  a_rx_clk_monitor: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (clk_role_q == epfm_pkg::EPFM_ROLE_MON_B) |=>
      eeprom_serial_clock_o == $past(rxclk_s))
    else $error("rx clock monitor wrong");

  a_ee_clock_pass: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    clk_ee |=> eeprom_serial_clock_o == $past(ee_clock_i))
    else $error("eeprom clock not passed");

  // reset state, checked on the edge after each reset edge
  a_roles_reset: assert property (
    @(posedge clk_i)
    sys_rst_i |=> data_ee && clk_ee && !eeprom_select_o)
    else $error("roles not home after reset");

  a_data_reset: assert property (
    @(posedge clk_i)
    sys_rst_i |=> !eeprom_data_io_oe_o && !eeprom_serial_clock_o)
    else $error("pins active after reset");

  a_width_reset: assert property (
    @(posedge clk_i)
    sys_rst_i |=> bus_width_o == epfm_pkg::EPFM_WIDTH_NARROW)
    else $error("bus width not narrow in reset");

  a_swap_reset: assert property (
    @(posedge clk_i)
    sys_rst_i |=> !pairs_swapped_o && pair_a_transmit_o)
    else $error("pairs swapped after reset");

  // width and crossover
  a_width_map: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    bus_width_o == (bus_width_strap_o ? epfm_pkg::EPFM_WIDTH_WIDE
                                      : epfm_pkg::EPFM_WIDTH_NARROW))
    else $error("bus width mismatch");

  a_swap_manual: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    reverse_manual_i |=> pair_b_transmit_o && !pair_a_transmit_o)
    else $error("manual reversal not applied");

  a_swap_auto: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (auto_s && det_s) |=> pairs_swapped_o)
    else $error("detected reversal not applied");

  a_auto_off: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (!reverse_manual_i && !auto_s) |=> !pairs_swapped_o)
    else $error("swap without crossover enable");

  a_swap_clear: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (!reverse_manual_i && !det_s) |=> !pairs_swapped_o)
    else $error("swap without any reversal");
endmodule : epfm_mux

// >>> dv/epfm_eeprom_model.sv
module epfm_eeprom_model (
  input  wire logic clk_i,
  input  wire logic select_i,
  input  wire logic drive_i,
  input  wire logic value_i,
  output logic      data_o,
  output logic      data_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // drives only while selected; serial command protocol not modelled
  always_ff @(posedge clk_i) begin
    data_oe_o <= select_i & drive_i;
    data_o    <= value_i;
  end
endmodule : epfm_eeprom_model

// >>> dv/epfm_mux_tb_top.sv
module epfm_mux_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, g3 = 0, g4 = 0, ten = 0, tck = 0, rdv = 0, rck = 0;
  logic eo = 0, eoe = 0, eck = 0, esel = 0, aut = 0, det = 0, man = 0;
  logic [1:0] dr = 0, cr = 0;
  logic mdrv = 0, mval = 0, sen = 1, sv = 1, last = 0, pin, mout, moe;
  logic din, pout, poe, sck, sel, swp, pa, pb, stp;
  logic [5:0] bw;
  logic [2:0] src;
  int fails = 0, compares = 0, cycles = 0;
  always #10 clk = ~clk;
  // released line shows a changing pattern, not a held value
  assign pin = poe ? pout : moe ? mout : sen ? sv : ~last;
  always @(posedge clk) last <= pin;
  epfm_eeprom_model epfm_eeprom_model_i (.clk_i(clk), .select_i(sel),
    .drive_i(mdrv), .value_i(mval), .data_o(mout), .data_oe_o(moe));
  epfm_mux epfm_mux_i (.clk_i(clk), .sys_rst_i(rst), .data_role_i(dr),
    .clk_role_i(cr), .general_output_3_i(g3), .general_output_4_i(g4),
    .mii_tx_en_i(ten), .mii_tx_clk_i(tck), .mii_rx_dv_i(rdv),
    .mii_rx_clk_i(rck), .ee_data_out_i(eo), .ee_data_oe_i(eoe),
    .ee_clock_i(eck), .ee_select_i(esel), .ee_data_in_o(din),
    .eeprom_data_io_i(pin), .eeprom_data_io_o(pout),
    .eeprom_data_io_oe_o(poe), .eeprom_serial_clock_o(sck),
    .eeprom_select_o(sel), .crossover_auto_enable_i(aut),
    .reverse_detected_i(det), .reverse_manual_i(man),
    .pairs_swapped_o(swp), .pair_a_transmit_o(pa),
    .pair_b_transmit_o(pb), .bus_width_strap_o(stp), .bus_width_o(bw));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk1(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %b got %b", n, e, g);
    end
  endtask : chk1
  task automatic chk6(input string n, input logic [5:0] e,
                      input logic [5:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk6
  task automatic strap_rst(input logic v);
    logic [5:0] w;
    w = v ? epfm_pkg::EPFM_WIDTH_WIDE : epfm_pkg::EPFM_WIDTH_NARROW;
    sen = 1;
    sv = v;
    rst = 1;
    cyc(3);
    chk1("strap in reset", epfm_pkg::EPFM_STRAP_RST, stp);
    rst = 0;
    // strap drive drops after the release edge: a late sample reads ~v
    cyc(1);
    sen = 0;
    cyc(2);
    chk1("strap", v, stp);
    chk6("width", w, bw);
  endtask : strap_rst
  task automatic role_chk(input logic ck, input logic [1:0] r);
    for (int v = 0; v < 2; v++) begin
      src = {3{~v[0]}};
      src[r-1] = v[0];
      if (ck) {rck, rdv, g4} = src;
      else {tck, ten, g3} = src;
      if (ck) cr = r;
      else dr = r;
      cyc(5);
      chk1("pin", v[0], ck ? sck : pout);
      chk1("select", 1'b0, sel);
      if (!ck) chk1("drive", 1'b1, poe);
    end
    dr = 0;
    cr = 0;
    cyc(3);
    chk1("select back", 1'b1, sel);
  endtask : role_chk
  task automatic finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    cyc(0);
    strap_rst(1'b1);
    {eo, eoe, eck, esel} = 4'b1111;
    cyc(3);
    chk1("dout", 1'b1, pout);
    chk1("doe", 1'b1, poe);
    chk1("sclk", 1'b1, sck);
    chk1("select", 1'b1, sel);
    eoe = 0;
    mdrv = 1;
    for (int v = 0; v < 2; v++) begin
      mval = v[0];
      cyc(6);
      chk1("din", v[0], din);
      chk1("doe", 1'b0, poe);
    end
    chk1("strap held", 1'b1, stp);
    for (int r = 1; r < 4; r++) role_chk(1'b0, r[1:0]);
    for (int r = 1; r < 4; r++) role_chk(1'b1, r[1:0]);
    esel = 0;
    cyc(3);
    chk1("select", 1'b0, sel);
    for (int i = 0; i < 8; i++) begin
      {aut, det, man} = i[2:0];
      cyc(5);
      chk1("swap", man | (aut & det), swp);
      chk1("pair a", ~(man | (aut & det)), pa);
      chk1("pair b", man | (aut & det), pb);
    end
    strap_rst(1'b0);
    finish_test();
  end
endmodule : epfm_mux_tb_top
